// [logic/encoder_feedback_pkg.sv]
// Purpose: shared constants and types for the encoder feedback block
// Assumes: axi4-lite register access, 32-bit data, 100 MHz clock
// Notes:   settings written by software act only after a restart
package encoder_feedback_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_WRAP_SET   = 8'h00;
	localparam logic [7:0] ADDR_PPR_SET    = 8'h04;
	localparam logic [7:0] ADDR_CONTROL    = 8'h08;
	localparam logic [7:0] ADDR_MULTITURN  = 8'h0c;
	localparam logic [7:0] ADDR_ACT_WRAP   = 8'h10;
	localparam logic [7:0] ADDR_ACT_PPR    = 8'h14;
	localparam logic [7:0] ADDR_POSITION   = 8'h18;

	// ----------------------------------------------------------------
	// field layout and values
	// ----------------------------------------------------------------
	localparam int CTRL_USAGE_BIT   = 0;
	localparam int CTRL_REVSEL_BIT  = 1;
	localparam int CTRL_RESTART_BIT = 8;

	localparam logic [15:0] WRAP_DEFAULT = 16'h000a;
	localparam logic [15:0] PPR_DEFAULT  = 16'h4000;
	localparam logic [15:0] PPR_MIN      = 16'h0010;
	localparam logic [15:0] PPR_MAX      = 16'h4000;
	localparam logic [15:0] LINES_MIN    = 16'h0010;
	localparam logic        USAGE_ABSOLUTE    = 1'b0;
	localparam logic        USAGE_INCREMENTAL = 1'b1;

	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] wrap;
		logic [15:0] ppr;
		logic        usage;
		logic        rev_sel;
	} cfg_t;

	typedef struct packed {
		logic step;
		logic dir;
		logic index;
	} enc_in_t;

endpackage : encoder_feedback_pkg

// [logic/encoder_feedback_output.sv]
// Purpose: multiturn revolution count and divided quadrature feedback
// Assumes: encoder delivers one step pulse per quadrature edge, with direction
// Notes:   settings are shadowed and applied at reset release or on restart
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// [RULE1] wrap setting 0..65535, default 10, restart-applied
// [RULE2] wrap behaviour only in absolute mode
// [RULE3] reverse at zero loads wrap minus one
// [RULE4] forward at wrap minus one clears
// [RULE5] single-turn or incremental holds count zero
// [RULE6] phases a and b in quadrature
// [RULE7] index output follows encoder phase c
// [RULE8] reverse select leaves output phase unchanged
// [RULE9] pulses setting 16..16384, default 16384, restart-applied
// [RULE10] scale outputs to configured pulses per revolution
// [RULE11] pulses limited by encoder resolution
// [RULE12] host counts quadrature pulses as feedback
// [RULE13] usage 0 absolute, 1 incremental, restart-applied
// [RULE14] a leads forward, b leads reverse
module encoder_feedback_output (
	input  wire logic                          clk,
	input  wire logic                          resetn,
	input  wire encoder_feedback_pkg::enc_in_t enc_in,
	input  wire logic                          enc_single_turn,
	input  wire logic [15:0]                   enc_lines_per_rev,
	output logic                               quad_out_a,
	output logic                               quad_out_b,
	output logic                               index_pulse_out,
	input  wire logic [7:0]                    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [7:0]                    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == encoder_feedback_pkg::ADDR_WRAP_SET)  ||
		              (a == encoder_feedback_pkg::ADDR_PPR_SET)   ||
		              (a == encoder_feedback_pkg::ADDR_CONTROL)   ||
		              (a == encoder_feedback_pkg::ADDR_MULTITURN) ||
		              (a == encoder_feedback_pkg::ADDR_ACT_WRAP)  ||
		              (a == encoder_feedback_pkg::ADDR_ACT_PPR)   ||
		              (a == encoder_feedback_pkg::ADDR_POSITION);
	endfunction : addr_mapped
	function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
	                                           input logic [31:0] data,
	                                           input logic [3:0]  strb);
		lane_merge = old_v;
		if (strb[0])
			lane_merge[7:0] = data[7:0];
		if (strb[1])
			lane_merge[15:8] = data[15:8];
	endfunction : lane_merge

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	encoder_feedback_pkg::cfg_t pend_r;
	encoder_feedback_pkg::cfg_t act_r;
	logic [15:0] lines_r;
	logic [15:0] ppr_eff_r;
	logic [15:0] ppr_clamp;
	logic [15:0] lines_clamp;
	logic        boot_r;
	logic        restart_r;
	logic        apply;
	logic        aw_held_r;
	logic [7:0]  aw_addr_r;
	logic        w_held_r;
	logic [31:0] w_data_r;
	logic [3:0]  w_strb_r;
	logic        wr_fire;
	logic [17:0] pos_r;
	logic [17:0] pos_max;
	logic        rev_fwd;
	logic        rev_back;
	logic [15:0] mt_r;
	logic [15:0] wrap_m1;
	logic        mt_hold;
	logic [15:0] acc_r;
	logic [16:0] acc_up;
	logic [1:0]  quad_r;
	logic        idx_r;

	// ----------------------------------------------------------------
	// axi4-lite write path
	// ----------------------------------------------------------------
	// address and data are taken in either order; response after both
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
	assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			aw_held_r <= 1'b0;
			aw_addr_r <= 8'h00;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r <= 1'b1;
			aw_addr_r <= s_axi_awaddr;
		end
		else if (wr_fire)
			aw_held_r <= 1'b0;
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end
		else if (wr_fire)
			w_held_r <= 1'b0;
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= encoder_feedback_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= addr_mapped(aw_addr_r) ? encoder_feedback_pkg::RESP_OKAY
			                                       : encoder_feedback_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// pending settings and restart
	// ----------------------------------------------------------------
	// writes land in the pending copy only; the logic runs on act_r
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pend_r.wrap    <= encoder_feedback_pkg::WRAP_DEFAULT; // [RULE1]
			pend_r.ppr     <= encoder_feedback_pkg::PPR_DEFAULT; // [RULE9]
			pend_r.usage   <= encoder_feedback_pkg::USAGE_ABSOLUTE; // [RULE13]
			pend_r.rev_sel <= 1'b0;
		end
		else if (wr_fire)
		begin
			case (aw_addr_r)
				encoder_feedback_pkg::ADDR_WRAP_SET:
					pend_r.wrap <= lane_merge(pend_r.wrap, w_data_r, w_strb_r);
				encoder_feedback_pkg::ADDR_PPR_SET:
					pend_r.ppr <= lane_merge(pend_r.ppr, w_data_r, w_strb_r);
				encoder_feedback_pkg::ADDR_CONTROL:
					if (w_strb_r[0])
					begin
						pend_r.usage   <= w_data_r[encoder_feedback_pkg::CTRL_USAGE_BIT];
						pend_r.rev_sel <= w_data_r[encoder_feedback_pkg::CTRL_REVSEL_BIT];
					end
				default: pend_r <= pend_r;
			endcase
		end
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			restart_r <= 1'b0;
		else
			restart_r <= wr_fire && (aw_addr_r == encoder_feedback_pkg::ADDR_CONTROL) &&
			             w_strb_r[1] && w_data_r[encoder_feedback_pkg::CTRL_RESTART_BIT];
	end
	// boot_r gives one apply cycle right after reset release, so the
	// encoder resolution strap is caught by a clocked load, not by reset
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			boot_r <= 1'b1;
		else
			boot_r <= 1'b0;
	end
	assign apply = boot_r || restart_r;
	// out-of-range pulse settings are clamped rather than refused
	assign ppr_clamp   = (pend_r.ppr < encoder_feedback_pkg::PPR_MIN) ? encoder_feedback_pkg::PPR_MIN :
	                     (pend_r.ppr > encoder_feedback_pkg::PPR_MAX) ? encoder_feedback_pkg::PPR_MAX :
	                     pend_r.ppr; // [RULE9]
	assign lines_clamp = (enc_lines_per_rev < encoder_feedback_pkg::LINES_MIN) ?
	                     encoder_feedback_pkg::LINES_MIN : enc_lines_per_rev;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			act_r.wrap    <= encoder_feedback_pkg::WRAP_DEFAULT;
			act_r.ppr     <= encoder_feedback_pkg::PPR_DEFAULT;
			act_r.usage   <= encoder_feedback_pkg::USAGE_ABSOLUTE;
			act_r.rev_sel <= 1'b0;
			lines_r       <= encoder_feedback_pkg::PPR_MAX;
			ppr_eff_r     <= encoder_feedback_pkg::PPR_MAX;
		end
		else if (apply)
		begin
			act_r.wrap    <= pend_r.wrap; // [RULE1]
			act_r.ppr     <= ppr_clamp; // [RULE9]
			act_r.usage   <= pend_r.usage; // [RULE13]
			act_r.rev_sel <= pend_r.rev_sel;
			lines_r       <= lines_clamp;
			ppr_eff_r     <= (ppr_clamp > lines_clamp) ? lines_clamp : ppr_clamp; // [RULE11]
		end
	end

	// ----------------------------------------------------------------
	// position within one revolution
	// ----------------------------------------------------------------
	assign pos_max  = {lines_r, 2'b00} - 18'h00001;
	assign rev_fwd  = enc_in.step && enc_in.dir && (pos_r == pos_max);
	assign rev_back = enc_in.step && !enc_in.dir && (pos_r == 18'h00000);
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pos_r <= 18'h00000;
		else if (apply || rev_fwd)
			pos_r <= 18'h00000;
		else if (rev_back)
			pos_r <= pos_max;
		else if (enc_in.step)
			pos_r <= enc_in.dir ? pos_r + 18'h00001 : pos_r - 18'h00001;
	end

	// ----------------------------------------------------------------
	// multiturn count
	// ----------------------------------------------------------------
	// a wrap setting of 0 makes wrap_m1 65535, i.e. the full 16-bit range
	assign wrap_m1 = act_r.wrap - 16'h0001;
	assign mt_hold = enc_single_turn || (act_r.usage == encoder_feedback_pkg::USAGE_INCREMENTAL);
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			mt_r <= 16'h0000;
		else if (mt_hold)
			mt_r <= 16'h0000; // [RULE5] [RULE2]
		else if (rev_fwd)
			mt_r <= (mt_r == wrap_m1) ? 16'h0000 : mt_r + 16'h0001; // [RULE4]
		else if (rev_back)
			mt_r <= (mt_r == 16'h0000) ? wrap_m1 : mt_r - 16'h0001; // [RULE3]
	end

	// ----------------------------------------------------------------
	// pulse divider and quadrature output
	// ----------------------------------------------------------------
	// rate accumulator: ppr_eff never exceeds lines, so at most one output
	// edge per encoder edge; reverse undoes forward exactly, no drift
	assign acc_up = {1'b0, acc_r} + {1'b0, ppr_eff_r};
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			acc_r  <= 16'h0000;
			quad_r <= 2'b00;
		end
		else if (apply)
			acc_r <= 16'h0000;
		else if (enc_in.step && enc_in.dir)
		begin
			if (acc_up >= {1'b0, lines_r})
			begin
				acc_r  <= 16'(acc_up - {1'b0, lines_r}); // [RULE10]
				quad_r <= quad_r + 2'b01; // [RULE14]
			end
			else
				acc_r <= acc_up[15:0];
		end
		else if (enc_in.step)
		begin
			if (acc_r < ppr_eff_r)
			begin
				acc_r  <= acc_r + lines_r - ppr_eff_r; // [RULE10]
				quad_r <= quad_r - 2'b01; // [RULE14]
			end
			else
				acc_r <= acc_r - ppr_eff_r;
		end
	end
	// gray decode of the step phase; rev_sel is deliberately not used here
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			quad_out_a <= 1'b0;
			quad_out_b <= 1'b0;
		end
		else
		begin
			quad_out_a <= quad_r[1] ^ quad_r[0]; // [RULE6] [RULE8]
			quad_out_b <= quad_r[1]; // [RULE6]
		end
	end
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			idx_r           <= 1'b0;
			index_pulse_out <= 1'b0;
		end
		else
		begin
			idx_r           <= enc_in.index;
			index_pulse_out <= idx_r; // [RULE7]
		end
	end

	// ----------------------------------------------------------------
	// axi4-lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= encoder_feedback_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= addr_mapped(s_axi_araddr) ? encoder_feedback_pkg::RESP_OKAY
			                                          : encoder_feedback_pkg::RESP_SLVERR;
			case (s_axi_araddr)
				encoder_feedback_pkg::ADDR_WRAP_SET:  s_axi_rdata <= {16'h0000, pend_r.wrap};
				encoder_feedback_pkg::ADDR_PPR_SET:   s_axi_rdata <= {16'h0000, pend_r.ppr};
				encoder_feedback_pkg::ADDR_CONTROL:
					s_axi_rdata <= {30'h0000_0000, pend_r.rev_sel, pend_r.usage};
				encoder_feedback_pkg::ADDR_MULTITURN: s_axi_rdata <= {16'h0000, mt_r};
				encoder_feedback_pkg::ADDR_ACT_WRAP:  s_axi_rdata <= {16'h0000, act_r.wrap};
				encoder_feedback_pkg::ADDR_ACT_PPR:   s_axi_rdata <= {16'h0000, ppr_eff_r};
				encoder_feedback_pkg::ADDR_POSITION:  s_axi_rdata <= {14'h0000, pos_r};
				default:                              s_axi_rdata <= 32'h0000_0000;
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule : encoder_feedback_output

`default_nettype wire

// [bench/encoder_feedback_chk.sv]
// Purpose: timing checks on the encoder feedback block ports
// Assumes: one clock domain, async active-low reset
// Notes:   bound to the design top at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module encoder_feedback_chk (
	input wire logic                          clk,
	input wire logic                          resetn,
	input wire encoder_feedback_pkg::enc_in_t enc_in,
	input wire logic                          quad_out_a,
	input wire logic                          quad_out_b,
	input wire logic                          index_pulse_out,
	input wire logic                          s_axi_awvalid,
	input wire logic                          s_axi_awready,
	input wire logic                          s_axi_wvalid,
	input wire logic                          s_axi_wready,
	input wire logic [1:0]                    s_axi_bresp,
	input wire logic                          s_axi_bvalid,
	input wire logic                          s_axi_bready,
	input wire logic                          s_axi_arvalid,
	input wire logic                          s_axi_arready,
	input wire logic [31:0]                   s_axi_rdata,
	input wire logic                          s_axi_rvalid,
	input wire logic                          s_axi_rready
);
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	AST_INDEX: assert property (index_pulse_out == $past(enc_in.index, 2))
		else $error("index output not two cycles behind phase c");
	AST_QUAD: assert property (!($changed(quad_out_a) && $changed(quad_out_b)))
		else $error("both quadrature phases moved together");
	AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted with response pending");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted with data pending");
endmodule : encoder_feedback_chk
bind encoder_feedback_output encoder_feedback_chk i_chk (.clk, .resetn, .enc_in, .quad_out_a,
	.quad_out_b, .index_pulse_out, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [bench/quad_host_model.sv]
// Purpose: host-side quadrature counter fed by the divided outputs
// Assumes: outputs are registered levels sampled each clock
// Notes:   a jump of two phases is counted as a fault
`timescale 1ns/1ns
`default_nettype none
module quad_host_model (
	input  wire logic   clk,
	input  wire logic   resetn,
	input  wire logic   a,
	input  wire logic   b,
	output var  integer count,
	output var  integer faults
);
	logic [1:0] prev_r;
	logic [1:0] now;
	assign now = {b, a ^ b};
	// host keeps its own position from the pulses; a leads counts up
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			prev_r <= 2'h0;
			count  <= 0;
			faults <= 0;
		end
		else
		begin
			prev_r <= now;
			if (now - prev_r == 2'h1)
				count <= count + 1;
			if (now - prev_r == 2'h3)
				count <= count - 1;
			if (now - prev_r == 2'h2)
				faults <= faults + 1;
		end
	end
endmodule : quad_host_model
`default_nettype wire

// [bench/tb.sv]
// Purpose: register and feedback tests of the encoder feedback block
// Assumes: 16 encoder lines, so 64 steps per revolution
// Notes:   settings take effect only through restart
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic                          clk = 0;
	logic                          resetn = 0;
	encoder_feedback_pkg::enc_in_t enc_in = '0;
	logic                          single = 0;
	logic [7:0]                    awaddr = 0, araddr = 0;
	logic [31:0]                   wdata = 0, rdata;
	logic [3:0]                    wstrb = 0;
	logic                          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic                          awready, wready, bvalid, arready, rvalid, qa, qb, idx;
	logic [1:0]                    bresp, rresp, r;
	logic [31:0]                   d;
	integer                        cnt, faults, c0;
	int                            mismatches = 0, total_checks = 0;
	always #5 clk = ~clk;
	encoder_feedback_output i_dut (.clk, .resetn, .enc_in, .enc_single_turn(single),
		.enc_lines_per_rev(16'h0010), .quad_out_a(qa), .quad_out_b(qb), .index_pulse_out(idx),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	quad_host_model i_host (.clk, .resetn, .a(qa), .b(qb), .count(cnt), .faults(faults));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : final_report
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic hang(input string n);
		mismatches++;
		$display("MISMATCH %s expected answer seen timeout", n);
		final_report();
	endtask : hang
	// the handshake is judged on what stood during the cycle, read mid-cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
		bit ta, tw, tb_, fin;
		fin = 1'b0;
		@(posedge clk);
		awaddr  <= a;
		wdata   <= v;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int n = 0; n < 50 && !fin; n++)
		begin
			@(negedge clk);
			ta  = awvalid && awready;
			tw  = wvalid && wready;
			tb_ = bvalid;
			r   = bresp;
			@(posedge clk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
			if (tb_)
				bready <= 1'b0;
			fin = tb_;
		end
		if (!fin)
			hang("write");
	endtask : wr
	task automatic rd(input logic [7:0] a);
		bit ta, fin;
		fin = 1'b0;
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int n = 0; n < 50 && !fin; n++)
		begin
			@(negedge clk);
			ta  = arvalid && arready;
			fin = rvalid;
			d   = rdata;
			r   = rresp;
			@(posedge clk);
			if (ta)
				arvalid <= 1'b0;
			if (fin)
				rready <= 1'b0;
		end
		if (!fin)
			hang("read");
	endtask : rd
	task automatic restart(input logic rev, input logic use_incr);
		wr(encoder_feedback_pkg::ADDR_CONTROL, {23'h0, 1'b1, 6'h0, rev, use_incr}, 4'h3);
	endtask : restart
	task automatic steps(input int n, input logic fwd);
		@(posedge clk);
		enc_in.step <= 1'b1;
		enc_in.dir  <= fwd;
		repeat (n) @(posedge clk);
		enc_in.step <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : steps
	task automatic turns(input logic [31:0] e);
		rd(encoder_feedback_pkg::ADDR_MULTITURN);
		chk("multiturn", e, d);
	endtask : turns
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		rd(encoder_feedback_pkg::ADDR_WRAP_SET);
		chk("wrap default", 32'h0000_000a, d);
		rd(encoder_feedback_pkg::ADDR_PPR_SET);
		chk("ppr default", 32'h0000_4000, d);
		rd(encoder_feedback_pkg::ADDR_ACT_PPR);
		chk("ppr limited", 32'h0000_0010, d);
		turns(32'h0000_0000);
		$display("test defaults done");
		rd(8'h1c);
		chk("unmapped read", {30'h0, encoder_feedback_pkg::RESP_SLVERR}, {d[29:0], r});
		wr(8'h1c, 32'h0000_0001, 4'hf);
		chk("unmapped write", {30'h0, encoder_feedback_pkg::RESP_SLVERR}, {30'h0, r});
		$display("test unmapped done");
		wr(encoder_feedback_pkg::ADDR_WRAP_SET, 32'h0000_0003, 4'h3);
		wr(encoder_feedback_pkg::ADDR_PPR_SET, 32'h0000_0008, 4'h3);
		rd(encoder_feedback_pkg::ADDR_ACT_WRAP);
		chk("wrap before restart", 32'h0000_000a, d);
		restart(1'b0, 1'b0);
		rd(encoder_feedback_pkg::ADDR_ACT_WRAP);
		chk("wrap applied", 32'h0000_0003, d);
		rd(encoder_feedback_pkg::ADDR_ACT_PPR);
		chk("ppr clamped", 32'h0000_0010, d);
		$display("test restart done");
		c0 = cnt;
		steps(64, 1'b1);
		turns(32'h0000_0001);
		steps(64, 1'b1);
		turns(32'h0000_0002);
		steps(64, 1'b1);
		turns(32'h0000_0000);
		chk("host forward", 32'h0000_00c0, cnt - c0);
		c0 = cnt;
		steps(64, 1'b0);
		turns(32'h0000_0002);
		chk("host reverse", 32'hffff_ffc0, cnt - c0);
		$display("test wrap done");
		restart(1'b1, 1'b0);
		rd(encoder_feedback_pkg::ADDR_CONTROL);
		chk("control readback", 32'h0000_0002, d);
		c0 = cnt;
		steps(64, 1'b1);
		turns(32'h0000_0000);
		chk("host reverse select", 32'h0000_0040, cnt - c0);
		$display("test reverse select done");
		restart(1'b0, 1'b1);
		steps(64, 1'b0);
		turns(32'h0000_0000);
		restart(1'b0, 1'b0);
		single <= 1'b1;
		steps(64, 1'b0);
		turns(32'h0000_0000);
		single <= 1'b0;
		$display("test held count done");
		@(posedge clk);
		enc_in.index <= 1'b1;
		repeat (3) @(posedge clk);
		chk("index copy", 32'h0000_0001, {31'h0, idx});
		enc_in.index <= 1'b0;
		repeat (3) @(posedge clk);
		chk("index release", 32'h0000_0000, {31'h0, idx});
		chk("host faults", 32'h0000_0000, faults);
		$display("test index done");
		final_report();
	end
endmodule : tb
`default_nettype wire
